// [hcore_pkg.sv]
// package for the ccd horizontal timing core: register map, field layouts,
// reset values and the edge grid. assumes an ahb-lite master with 32-bit words.
package hcore_pkg;

  // edge grid
  localparam int          GRID_STEPS   = 48;
  localparam int          QUAD_SIZE    = 12;
  localparam logic [5:0]  GRID_LAST    = 6'h2F;
  localparam logic [3:0]  QUAD_LOW_MAX = 4'hB;

  // clock rate
  localparam int          MCLK_HZ      = 25000000;

  // register byte offsets
  localparam logic [7:0] OFS_POL     = 8'h00;
  localparam logic [7:0] OFS_HEDGE   = 8'h04;
  localparam logic [7:0] OFS_RG1EDGE = 8'h08;
  localparam logic [7:0] OFS_RG2EDGE = 8'h0C;
  localparam logic [7:0] OFS_SAMPLE  = 8'h10;
  localparam logic [7:0] OFS_DRIVE   = 8'h14;
  localparam logic [7:0] OFS_BLANK0  = 8'h18;
  localparam logic [7:0] OFS_BLANK1  = 8'h1C;
  localparam logic [7:0] OFS_BLANK2  = 8'h20;
  localparam logic [7:0] OFS_LINE    = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;

  // field positions
  localparam int POS_RISE   = 0;
  localparam int POS_FALL   = 8;
  localparam int POS_HDRV   = 0;
  localparam int POS_RGDRV  = 4;
  localparam int POS_HLDRV  = 8;
  localparam int POS_WSTART = 0;
  localparam int POS_WEND   = 16;

  // reset values
  localparam logic [5:0]  RST_EDGE_RISE = 6'h00;
  localparam logic [5:0]  RST_EDGE_FALL = 6'h20;
  localparam logic [5:0]  RST_REF_POS   = 6'h20;
  localparam logic [5:0]  RST_DATA_POS  = 6'h00;
  localparam logic [3:0]  RST_HDRV      = 4'h0;
  localparam logic [2:0]  RST_SDRV      = 3'h0;
  localparam logic [15:0] RST_LINE_LEN  = 16'h0400;

  // one edge setting: polarity, rising and falling code
  typedef struct packed {
    logic       invert;
    logic [5:0] rise;
    logic [5:0] fall;
  } hcore_edge_t;

  // one blanking window in pixel counts
  typedef struct packed {
    logic [15:0] start_pos;
    logic [15:0] end_pos;
  } hcore_window_t;

  // driver strengths
  typedef struct packed {
    logic [3:0] horiz;
    logic [2:0] reset_gate;
    logic [2:0] last_stage;
  } hcore_drive_t;

endpackage

// [hcore_edge_gen.sv]
// one programmable edge channel on the 48-step grid: decodes rise and fall codes,
// produces the phase-domain level and applies polarity.
// assumes step counts 0..47 once per pixel period, synchronous to mclk.
`timescale 1ns/1ns
module hcore_edge_gen (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // grid position and setting
  input  wire logic [5:0]           step,
  input  wire hcore_pkg::hcore_edge_t cfg,
  // output level, registered
  output logic                      level_q
);

  logic [5:0] rise_pos;
  logic [5:0] fall_pos;
  logic       raw_d;
  logic       raw_q;

  // quadrant code to linear position
  function automatic logic [5:0] quad_to_pos(input logic [5:0] code);
    logic [5:0] base;
    base = 6'(code[5:4] * hcore_pkg::QUAD_SIZE);
    quad_to_pos = base + {2'h0, code[3:0]};
  endfunction

  assign rise_pos = quad_to_pos(cfg.rise);
  assign fall_pos = quad_to_pos(cfg.fall);

  always_comb begin
    raw_d = raw_q;
    if (step == rise_pos) begin
      raw_d = 1'b1;
    end else if (step == fall_pos) begin
      raw_d = 1'b0;
    end
  end

  // raw waveform state
  always_ff @(posedge mclk) begin
    if (srst) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= raw_d ^ cfg.invert;
    end
  end

endmodule // hcore_edge_gen

// [hcore_top.sv]
// top of the ccd horizontal timing core with its ahb-lite register slave.
// assumes one ahb-lite master, single word transfers, mclk at 25 MHz.
// the 48-step grid is modelled as a step counter at mclk; each 48 steps is one pixel.
//
// What this block does
// - polarity bit per horizontal and reset-gate channel: 0 keeps waveform, 1 inverts it
// - six-bit rising position, valid grid positions 0 to 47
// - six-bit falling position, valid grid positions 0 to 47
// - separate six-bit reference and data sample positions, 0 to 47
// - four-bit drive code 0 to 15 for horizontal drivers
// - three-bit drive code 0 to 7 for reset-gate driver
// - three-bit drive code 0 to 7 for last-stage driver
// - codes decode as quadrant times twelve plus low bits; 12-15 invalid
// - pixel period split into 48 equal edge steps
// - pair b always the inverse of final pair a outputs
// - blanking windows defined by start and end toggle positions
// - mask level high: pair a high, pair b low while blanking
// - three windows per line, handled in order from window 0
// - drive code zero puts the driver in high impedance
`timescale 1ns/1ns
module hcore_top #(
  parameter int NUM_WINDOWS = 3,
  parameter int LINE_BITS   = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // sensor clocks, enables low while driven
  output logic             horiz_clock_pair_a,
  output logic             horiz_clock_pair_a_oe_n,
  output logic             horiz_clock_pair_b,
  output logic             horiz_clock_pair_b_oe_n,
  output logic             reset_gate_out_one,
  output logic             reset_gate_out_two,
  output logic             reset_gate_oe_n,
  output logic             last_stage_horiz_clock,
  output logic             last_stage_oe_n,
  // internal sample clocks and driver codes
  output logic             reference_sample_clock,
  output logic             data_sample_clock,
  output hcore_pkg::hcore_drive_t drive_code_q,
  output logic             horiz_blanking
);

  // register state
  logic                     blank_mask_level_q;
  hcore_pkg::hcore_edge_t   hedge_q;
  hcore_pkg::hcore_edge_t   rg1_q;
  hcore_pkg::hcore_edge_t   rg2_q;
  logic [5:0]               ref_pos_q;
  logic [5:0]               data_pos_q;
  hcore_pkg::hcore_window_t win_q [NUM_WINDOWS];
  logic [LINE_BITS-1:0]     line_len_q;
  logic                     bad_code_q;

  // bus pipeline
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       take;

  // timing state
  logic [5:0]           step_q;
  logic [LINE_BITS-1:0] pix_q;
  logic [1:0]           win_idx_q;
  logic                 blank_q;
  logic                 blank_d;
  logic                 pair_a_raw;
  logic                 rg1_lvl;
  logic                 rg2_lvl;
  logic                 ref_lvl_q;
  logic                 data_lvl_q;

  // quadrant code validity, low nibble 12..15 is not a grid slot
  function automatic logic code_bad(input logic [5:0] code);
    code_bad = code[3:0] > hcore_pkg::QUAD_LOW_MAX;
  endfunction

  // quadrant code to linear grid position
  function automatic logic [5:0] code_pos(input logic [5:0] code);
    code_pos = 6'(code[5:4] * hcore_pkg::QUAD_SIZE) + {2'h0, code[3:0]};
  endfunction

  // address phase accepted
  assign take = hsel & hready & htrans[1];

  // data phase capture, always zero wait states
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // fixed okay answer with no wait
  always_ff @(posedge mclk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      blank_mask_level_q <= 1'b0;
      hedge_q <= '{1'b0, hcore_pkg::RST_EDGE_RISE, hcore_pkg::RST_EDGE_FALL};
      rg1_q   <= '{1'b0, hcore_pkg::RST_EDGE_RISE, hcore_pkg::RST_EDGE_FALL};
      rg2_q   <= '{1'b0, hcore_pkg::RST_EDGE_RISE, hcore_pkg::RST_EDGE_FALL};
    end else if (wr_pend_q) begin
      if (addr_q == hcore_pkg::OFS_POL) begin
        hedge_q.invert     <= hwdata[0];
        rg1_q.invert       <= hwdata[1];
        rg2_q.invert       <= hwdata[2];
        blank_mask_level_q <= hwdata[3];
      end else if (addr_q == hcore_pkg::OFS_HEDGE) begin
        hedge_q.rise <= hwdata[hcore_pkg::POS_RISE +: 6];
        hedge_q.fall <= hwdata[hcore_pkg::POS_FALL +: 6];
      end else if (addr_q == hcore_pkg::OFS_RG1EDGE) begin
        rg1_q.rise <= hwdata[hcore_pkg::POS_RISE +: 6];
        rg1_q.fall <= hwdata[hcore_pkg::POS_FALL +: 6];
      end else if (addr_q == hcore_pkg::OFS_RG2EDGE) begin
        rg2_q.rise <= hwdata[hcore_pkg::POS_RISE +: 6];
        rg2_q.fall <= hwdata[hcore_pkg::POS_FALL +: 6];
      end
    end
  end

  // sample positions and drive codes written
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_pos_q    <= hcore_pkg::RST_REF_POS;
      data_pos_q   <= hcore_pkg::RST_DATA_POS;
      drive_code_q <= '{hcore_pkg::RST_HDRV, hcore_pkg::RST_SDRV, hcore_pkg::RST_SDRV};
    end else if (wr_pend_q) begin
      if (addr_q == hcore_pkg::OFS_SAMPLE) begin
        ref_pos_q  <= hwdata[hcore_pkg::POS_RISE +: 6];
        data_pos_q <= hwdata[hcore_pkg::POS_FALL +: 6];
      end else if (addr_q == hcore_pkg::OFS_DRIVE) begin
        drive_code_q.horiz      <= hwdata[hcore_pkg::POS_HDRV +: 4];
        drive_code_q.reset_gate <= hwdata[hcore_pkg::POS_RGDRV +: 3];
        drive_code_q.last_stage <= hwdata[hcore_pkg::POS_HLDRV +: 3];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < NUM_WINDOWS; i++) begin
        win_q[i] <= '0;
      end
      line_len_q <= LINE_BITS'(hcore_pkg::RST_LINE_LEN);
    end else if (wr_pend_q) begin
      if (addr_q == hcore_pkg::OFS_BLANK0) begin
        win_q[0] <= '{hwdata[hcore_pkg::POS_WSTART +: 16], hwdata[hcore_pkg::POS_WEND +: 16]};
      end else if (addr_q == hcore_pkg::OFS_BLANK1) begin
        win_q[1] <= '{hwdata[hcore_pkg::POS_WSTART +: 16], hwdata[hcore_pkg::POS_WEND +: 16]};
      end else if (addr_q == hcore_pkg::OFS_BLANK2) begin
        win_q[2] <= '{hwdata[hcore_pkg::POS_WSTART +: 16], hwdata[hcore_pkg::POS_WEND +: 16]};
      end else if (addr_q == hcore_pkg::OFS_LINE) begin
        line_len_q <= hwdata[LINE_BITS-1:0];
      end
    end
  end

  // read data registered in the data phase; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      if (haddr[7:0] == hcore_pkg::OFS_POL) begin
        hrdata <= {28'h0000000, blank_mask_level_q, rg2_q.invert, rg1_q.invert, hedge_q.invert};
      end else if (haddr[7:0] == hcore_pkg::OFS_HEDGE) begin
        hrdata <= {18'h00000, hedge_q.fall, 2'h0, hedge_q.rise};
      end else if (haddr[7:0] == hcore_pkg::OFS_RG1EDGE) begin
        hrdata <= {18'h00000, rg1_q.fall, 2'h0, rg1_q.rise};
      end else if (haddr[7:0] == hcore_pkg::OFS_RG2EDGE) begin
        hrdata <= {18'h00000, rg2_q.fall, 2'h0, rg2_q.rise};
      end else if (haddr[7:0] == hcore_pkg::OFS_SAMPLE) begin
        hrdata <= {18'h00000, data_pos_q, 2'h0, ref_pos_q};
      end else if (haddr[7:0] == hcore_pkg::OFS_DRIVE) begin
        hrdata <= {21'h000000, drive_code_q.last_stage, 1'b0, drive_code_q.reset_gate, drive_code_q.horiz};
      end else if (haddr[7:0] == hcore_pkg::OFS_BLANK0) begin
        hrdata <= {win_q[0].end_pos, win_q[0].start_pos};
      end else if (haddr[7:0] == hcore_pkg::OFS_BLANK1) begin
        hrdata <= {win_q[1].end_pos, win_q[1].start_pos};
      end else if (haddr[7:0] == hcore_pkg::OFS_BLANK2) begin
        hrdata <= {win_q[2].end_pos, win_q[2].start_pos};
      end else if (haddr[7:0] == hcore_pkg::OFS_LINE) begin
        hrdata <= 32'(line_len_q);
      end else if (haddr[7:0] == hcore_pkg::OFS_STATUS) begin
        // live position and blanking state, plus invalid-code flag
        hrdata <= {bad_code_q, 5'h00, win_idx_q, blank_q, 1'b0, step_q, pix_q};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // flag any code with low nibble above eleven
  always_ff @(posedge mclk) begin
    if (srst) begin
      bad_code_q <= 1'b0;
    end else begin
      bad_code_q <= code_bad(hedge_q.rise) | code_bad(hedge_q.fall) | code_bad(rg1_q.rise) |
                    code_bad(rg1_q.fall) | code_bad(rg2_q.rise) | code_bad(rg2_q.fall) |
                    code_bad(ref_pos_q) | code_bad(data_pos_q);
    end
  end

  // 48-step grid counter and pixel count within line
  always_ff @(posedge mclk) begin
    if (srst) begin
      step_q <= 6'h00;
      pix_q  <= '0;
    end else if (step_q == hcore_pkg::GRID_LAST) begin
      step_q <= 6'h00;
      pix_q  <= (pix_q >= line_len_q - 1'b1) ? '0 : pix_q + 1'b1;
    end else begin
      step_q <= step_q + 6'h01;
    end
  end

  // windows walked in order, one active index at a time
  always_comb begin
    blank_d = blank_q;
    if (!blank_q && pix_q == win_q[win_idx_q].start_pos) begin
      blank_d = 1'b1;
    end else if (blank_q && pix_q == win_q[win_idx_q].end_pos) begin
      blank_d = 1'b0;
    end
  end

  // toggle pairs open and close blanking
  always_ff @(posedge mclk) begin
    if (srst) begin
      blank_q   <= 1'b0;
      win_idx_q <= 2'h0;
    end else if (step_q == hcore_pkg::GRID_LAST && pix_q >= line_len_q - 1'b1) begin
      // new line restarts from window 0
      blank_q   <= 1'b0;
      win_idx_q <= 2'h0;
    end else if (step_q == hcore_pkg::GRID_LAST) begin
      blank_q <= blank_d;
      if (blank_q && !blank_d && win_idx_q < 2'(NUM_WINDOWS - 1)) begin
        win_idx_q <= win_idx_q + 2'h1;
      end
    end
  end

  // horizontal pair channel
  hcore_edge_gen u_hedge (
    .mclk    (mclk),
    .srst    (srst),
    .step    (step_q),
    .cfg     (hedge_q),
    .level_q (pair_a_raw)
  );

  // reset gate one channel
  hcore_edge_gen u_rg1 (
    .mclk    (mclk),
    .srst    (srst),
    .step    (step_q),
    .cfg     (rg1_q),
    .level_q (rg1_lvl)
  );

  // reset gate two channel
  hcore_edge_gen u_rg2 (
    .mclk    (mclk),
    .srst    (srst),
    .step    (step_q),
    .cfg     (rg2_q),
    .level_q (rg2_lvl)
  );

  // sample clocks pulse at their grid slot
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_lvl_q  <= 1'b0;
      data_lvl_q <= 1'b0;
    end else begin
      ref_lvl_q  <= (step_q == code_pos(ref_pos_q));
      data_lvl_q <= (step_q == code_pos(data_pos_q));
    end
  end

  // blanking masks pair a to the mask level
  always_ff @(posedge mclk) begin
    if (srst) begin
      horiz_clock_pair_a     <= 1'b0;
      horiz_clock_pair_b     <= 1'b1;
      last_stage_horiz_clock <= 1'b0;
    end else if (blank_q) begin
      horiz_clock_pair_a     <= blank_mask_level_q;
      // pair b inverse of pair a
      horiz_clock_pair_b     <= ~blank_mask_level_q;
      last_stage_horiz_clock <= blank_mask_level_q;
    end else begin
      horiz_clock_pair_a     <= pair_a_raw;
      horiz_clock_pair_b     <= ~pair_a_raw;
      last_stage_horiz_clock <= pair_a_raw;
    end
  end

  // remaining registered outputs, aligned with the horizontal pair
  always_ff @(posedge mclk) begin
    if (srst) begin
      reset_gate_out_one     <= 1'b0;
      reset_gate_out_two     <= 1'b0;
      reference_sample_clock <= 1'b0;
      data_sample_clock      <= 1'b0;
      horiz_blanking         <= 1'b0;
    end else begin
      reset_gate_out_one     <= rg1_lvl;
      reset_gate_out_two     <= rg2_lvl;
      reference_sample_clock <= ref_lvl_q;
      data_sample_clock      <= data_lvl_q;
      horiz_blanking         <= blank_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      horiz_clock_pair_a_oe_n <= 1'b1;
      horiz_clock_pair_b_oe_n <= 1'b1;
      reset_gate_oe_n         <= 1'b1;
      last_stage_oe_n         <= 1'b1;
    end else begin
      horiz_clock_pair_a_oe_n <= (drive_code_q.horiz == 4'h0);
      horiz_clock_pair_b_oe_n <= (drive_code_q.horiz == 4'h0);
      reset_gate_oe_n         <= (drive_code_q.reset_gate == 3'h0);
      last_stage_oe_n         <= (drive_code_q.last_stage == 3'h0);
    end
  end

  // pair b always opposite pair a
  AST_PAIR_INVERSE: assert property (@(posedge mclk) disable iff (srst)
    horiz_clock_pair_b == ~horiz_clock_pair_a) else $error("pair b not inverse of pair a");
  AST_MASK_HIGH: assert property (@(posedge mclk) disable iff (srst)
    blank_q && blank_mask_level_q |=> horiz_clock_pair_a && !horiz_clock_pair_b) else $error("mask high wrong");
  AST_MASK_LOW: assert property (@(posedge mclk) disable iff (srst)
    blank_q && !blank_mask_level_q |=> !horiz_clock_pair_a) else $error("mask low wrong");
  AST_GRID_WRAP: assert property (@(posedge mclk) disable iff (srst)
    step_q == 6'h2F |=> step_q == 6'h00) else $error("grid did not wrap at 47");
  AST_GRID_RANGE: assert property (@(posedge mclk) disable iff (srst)
    step_q <= 6'h2F) else $error("grid step out of range");
  AST_DRV_OFF: assert property (@(posedge mclk) disable iff (srst)
    drive_code_q.reset_gate == 3'h0 && $stable(drive_code_q.reset_gate) |=> reset_gate_oe_n)
    else $error("rg driver not released");
  // reference clock follows its slot by two cycles
  AST_REF_SLOT: assert property (@(posedge mclk) disable iff (srst)
    step_q == code_pos(ref_pos_q) && $stable(ref_pos_q) |=> ##1 reference_sample_clock)
    else $error("reference sample late");
  // window index only moves forward inside a line
  AST_WIN_ORDER: assert property (@(posedge mclk) disable iff (srst)
    win_idx_q != $past(win_idx_q) |-> win_idx_q == $past(win_idx_q) + 2'h1 || win_idx_q == 2'h0)
    else $error("window order broken");

endmodule // hcore_top

// [hcore_ccd_model.sv]
// sensor-side model of the horizontal register clock inputs.
// assumes the core drives a line while its enable is low.
`timescale 1ns/1ns
module hcore_ccd_model (
  // clock
  input  wire logic        mclk,
  // horizontal pair lines and their enables
  input  wire logic        pair_a,
  input  wire logic        pair_a_oe_n,
  input  wire logic        pair_b,
  input  wire logic        pair_b_oe_n,
  // charge transfers seen
  output logic [15:0]      transfer_count
);
  logic a_line = 1'b0;
  logic b_line = 1'b0;

  // released line
  // a floating line shows the inverse of its last value, never a held copy
  always @(posedge mclk) begin
    a_line <= pair_a_oe_n ? ~a_line : pair_a;
    b_line <= pair_b_oe_n ? ~b_line : pair_b;
  end

  // complementary crossing
  // only a true crossing of both phases moves charge; released lines toggle together
  logic [15:0] count_q = 16'h0;
  assign transfer_count = count_q;
  always @(posedge mclk) begin
    if (!a_line && pair_a === 1'b1 && !pair_a_oe_n && !pair_b_oe_n && pair_b === 1'b0)
      count_q <= count_q + 16'h1;
  end
endmodule // hcore_ccd_model

// [ccd_horizontal_timing_core_bench.sv]
// testbench for the horizontal timing core: ahb-lite master, sensor model, checks.
// assumes one slave whose hreadyout is the bus hready, mclk at 25 MHz.
`timescale 1ns/1ns
module ccd_horizontal_timing_core_bench;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, hready;
  logic        horiz_clock_pair_a, horiz_clock_pair_a_oe_n, horiz_clock_pair_b, horiz_clock_pair_b_oe_n;
  logic        reset_gate_out_one, reset_gate_out_two, reset_gate_oe_n;
  logic        last_stage_horiz_clock, last_stage_oe_n;
  logic        reference_sample_clock, data_sample_clock, horiz_blanking;
  hcore_pkg::hcore_drive_t drive_code_q;
  logic [15:0] transfer_count;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  assign hready = hreadyout;
  always #20 mclk = ~mclk;

  hcore_top hcore_top_inst (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .horiz_clock_pair_a, .horiz_clock_pair_a_oe_n, .horiz_clock_pair_b,
    .horiz_clock_pair_b_oe_n, .reset_gate_out_one, .reset_gate_out_two, .reset_gate_oe_n,
    .last_stage_horiz_clock, .last_stage_oe_n, .reference_sample_clock, .data_sample_clock,
    .drive_code_q, .horiz_blanking);
  hcore_ccd_model hcore_ccd_model_inst (.mclk, .pair_a(horiz_clock_pair_a),
    .pair_a_oe_n(horiz_clock_pair_a_oe_n), .pair_b(horiz_clock_pair_b),
    .pair_b_oe_n(horiz_clock_pair_b_oe_n), .transfer_count);

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, well above the roughly 10k cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  always @(negedge mclk) begin
    if (!srst) begin
      check("pair b", {31'h0, ~horiz_clock_pair_a}, {31'h0, horiz_clock_pair_b});
      check("last stage", {31'h0, horiz_clock_pair_a}, {31'h0, last_stage_horiz_clock});
    end
  end

  // one single word transfer; signals change only after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask

  function automatic int dec(input logic [5:0] c);
    return c[5:4] * hcore_pkg::QUAD_SIZE + c[3:0];
  endfunction

  function automatic logic pick(input int ch);
    case (ch)
      0: return horiz_clock_pair_a;
      1: return reset_gate_out_one;
      2: return reset_gate_out_two;
      3: return reference_sample_clock;
      default: return data_sample_clock;
    endcase
  endfunction

  // sampled at falling edges so registered outputs have settled
  task automatic rise(input int ch);
    logic p;
    int   n;
    n = 0;
    p = pick(ch);
    @(negedge mclk);
    while (!(p === 1'b0 && pick(ch) === 1'b1) && n < 200) begin
      p = pick(ch);
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic span(input int ch, output int hi, output int per);
    rise(ch);
    hi = 0;
    per = 0;
    while (pick(ch) === 1'b1 && per < 100) begin
      @(negedge mclk);
      hi++;
      per++;
    end
    while (pick(ch) === 1'b0 && per < 100) begin
      @(negedge mclk);
      per++;
    end
  endtask

  // wait for the long unblanked stretch that follows window 2
  // counting starts only after a blank, so most of the stretch is still ahead
  task automatic quiet();
    int n;
    n = -1;
    while (n < 200) begin
      @(negedge mclk);
      if (horiz_blanking === 1'b1)
        n = 0;
      else if (n >= 0)
        n++;
    end
  endtask

  task automatic test_reset();
    check("pair a oe_n", 32'h1, {31'h0, horiz_clock_pair_a_oe_n});
    check("hresp", 32'h0, {31'h0, hresp});
    check("hreadyout", 32'h1, {31'h0, hreadyout});
    rd("edge reset", hcore_pkg::OFS_HEDGE, 32'h2000);
    rd("sample reset", hcore_pkg::OFS_SAMPLE, 32'h20);
    rd("drive reset", hcore_pkg::OFS_DRIVE, 32'h0);
    rd("unmapped", 8'h2C, 32'h0);
  endtask

  task automatic test_edges(input logic inv);
    logic [5:0] r[3] = '{6'h13, 6'h00, 6'h3A};
    logic [5:0] f[3] = '{6'h25, 6'h1B, 6'h05};
    int         hi, per, e;
    wr(hcore_pkg::OFS_POL, {29'h0, {3{inv}}});
    for (int ch = 0; ch < 3; ch++)
      wr(8'(hcore_pkg::OFS_HEDGE + 4 * ch), {18'h0, f[ch], 2'h0, r[ch]});
    for (int ch = 0; ch < 3; ch++) begin
      e = (dec(f[ch]) - dec(r[ch]) + 48) % 48;
      quiet();
      span(ch, hi, per);
      check("edge period", 32'(hcore_pkg::GRID_STEPS), 32'(per));
      check("edge high", 32'(inv ? 48 - e : e), 32'(hi));
    end
  endtask

  task automatic test_sample();
    int hi, per, n;
    wr(hcore_pkg::OFS_SAMPLE, 32'h3A05);
    span(3, hi, per);
    check("sample width", 32'h1, 32'(hi));
    check("sample period", 32'h30, 32'(per));
    rise(3);
    n = 0;
    while (data_sample_clock !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    check("sample gap", 32'((dec(6'h3A) - dec(6'h05) + 48) % 48), 32'(n));
  endtask

  task automatic test_blank(input logic lvl);
    int g, h;
    wr(hcore_pkg::OFS_POL, {28'h0, lvl, 3'h0});
    quiet();
    for (int k = 0; k < 3; k++) begin
      g = 0;
      h = 0;
      while (horiz_blanking !== 1'b1 && g < 2000) begin
        @(negedge mclk);
        g++;
      end
      if (k > 0)
        check("blank gap", 32'h60, 32'(g));
      while (horiz_blanking === 1'b1 && h < 200) begin
        if (h >= 4 && h < 40)
          check("masked pair a", {31'h0, lvl}, {31'h0, horiz_clock_pair_a});
        @(negedge mclk);
        h++;
      end
      check("blank length", k == 0 ? 32'h60 : 32'h30, 32'(h));
    end
  endtask

  task automatic test_drive();
    logic [3:0]  h[3] = '{4'h0, 4'h1, 4'hF};
    logic [2:0]  g[3] = '{3'h0, 3'h7, 3'h3};
    logic [2:0]  l[3] = '{3'h0, 3'h1, 3'h7};
    logic [15:0] t;
    for (int k = 0; k < 3; k++) begin
      wr(hcore_pkg::OFS_DRIVE, {21'h0, l[k], 1'h0, g[k], h[k]});
      repeat (3) @(negedge mclk);
      check("drive code", {22'h0, h[k], g[k], l[k]}, {22'h0, drive_code_q});
      check("rg oe_n", {31'h0, g[k] == 3'h0}, {31'h0, reset_gate_oe_n});
      check("hl oe_n", {31'h0, l[k] == 3'h0}, {31'h0, last_stage_oe_n});
      check("pair a oe_n", {31'h0, h[k] == 4'h0}, {31'h0, horiz_clock_pair_a_oe_n});
      check("pair b oe_n", {31'h0, h[k] == 4'h0}, {31'h0, horiz_clock_pair_b_oe_n});
      t = transfer_count;
      repeat (300) @(negedge mclk);
      check("transfers moved", {31'h0, k > 0}, {31'h0, transfer_count != t});
    end
  endtask

  initial begin
    logic [31:0] q;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    test_reset();
    wr(hcore_pkg::OFS_LINE, 32'h14);
    wr(hcore_pkg::OFS_BLANK0, 32'h000C000A);
    wr(hcore_pkg::OFS_BLANK1, 32'h000F000E);
    wr(hcore_pkg::OFS_BLANK2, 32'h00120011);
    test_drive();
    test_edges(1'b0);
    test_edges(1'b1);
    test_sample();
    test_blank(1'b1);
    test_blank(1'b0);
    // status also holds live position, so only the flag bit is judged
    bus(1'b0, hcore_pkg::OFS_STATUS, 32'h0, q);
    check("valid flag", 32'h0, {31'h0, q[31]});
    wr(hcore_pkg::OFS_HEDGE, 32'h250C);
    bus(1'b0, hcore_pkg::OFS_STATUS, 32'h0, q);
    check("invalid flag", 32'h1, {31'h0, q[31]});
    results();
  end
endmodule // ccd_horizontal_timing_core_bench
